// ===== rtl/fbg_baud_gen.sv
// One channel's fractional baud rate generator with its registers
//
// Behaviour
// (R1) Every channel owns its own generator and prescaler for tx and rx.
// (R2) Reference is the oscillator input; register access never needs it.
// (R3) Modem control bit 7 picks reference divide by 1 or by 4.
// (R4) Divisor runs 1 to 65537 minus 1/16 in sixteenths.
// (R5) Sampling tick drives transmitter shifting and receiver sampling.
// (R6) Reset divisor is one: low 0x01, high 0x00, fraction 0x00.
// (R7) Low and high bytes form integer part; fraction register the rest.
// (R8) Fraction bits 3:0 give zero to fifteen sixteenths.
// (R9) Fraction bits 5:4 pick 16, 8 or 4 samples per bit.
// (R10) 8X mode with odd fraction may jitter one sixteenth; accepted.
// (R11) Software must program the divisor at initialisation.
// (R12) Software computes divisor from reference, prescaler, rate, factor.
// (R13) Software splits divisor into high, low and fraction bytes.
// (R14) Strap pin sets prescaler default after reset; software may override.
// (R15) One bit lasts 16, 8 or 4 sampling periods per mode.
// (R16) Extra ticks spread over sixteen periods so average equals divisor.
// (R17) New settings apply at next reload without a short pulse.
`timescale 1ns/1ps
module fbg_baud_gen
  import fbg_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  input  wire logic              i_oscillator_input,
  output logic                   o_oscillator_output,
  input  wire logic              i_prescaler_default_select_pin,
  output logic                   o_sample_tick,
  output logic                   o_bit_tick
);
  fbg_div_if dif ();

  // Pin synchronisers; stage one feeds only stage two
  logic       osc_s1_r;
  logic       osc_s2_r;
  logic       osc_s3_r;
  logic       sel_s1_r;
  logic       sel_s2_r;

  // Reset high, so a reference stopped at either level shows no false edge
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_s1_r <= 1'b1;
      osc_s2_r <= 1'b1;
      osc_s3_r <= 1'b1;
    end else begin
      osc_s1_r <= i_oscillator_input;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // Strap sync runs through reset so its level is ready at release
  always_ff @(posedge i_mclk) begin
    sel_s1_r <= i_prescaler_default_select_pin;         // [R14]
    sel_s2_r <= sel_s1_r;
  end

  // Reference must run below a quarter of i_mclk to be counted faithfully
  logic ref_rise;
  assign ref_rise = osc_s2_r & ~osc_s3_r;                // [R2]

  // Register group
  logic [7:0] div_low_r;
  logic [7:0] div_low_nxt;
  logic [7:0] div_high_r;
  logic [7:0] div_high_nxt;
  logic [7:0] div_frac_r;
  logic [7:0] div_frac_nxt;
  logic [7:0] mcr_r;
  logic [7:0] mcr_nxt;
  logic       strap_done_r;
  logic       strap_done_nxt;
  logic       ref_seen_r;
  logic       ref_seen_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status;

  always_comb begin
    status                      = 8'h00;
    status[ST_PRESC_BIT]        = mcr_r[MCR_PRESC_BIT];
    status[ST_REF_BIT]          = ref_seen_r;
    status[ST_MODE_LSB+:MODE_W] = dif.act_mode;
  end

  always_comb begin
    div_low_nxt    = div_low_r;
    div_high_nxt   = div_high_r;
    div_frac_nxt   = div_frac_r;
    mcr_nxt        = mcr_r;
    strap_done_nxt = 1'b1;
    ref_seen_nxt   = ref_seen_r;
    rdata_nxt      = 8'h00;
    // Strap taken once after release; a host write that cycle wins
    if (!strap_done_r) begin
      mcr_nxt[MCR_PRESC_BIT] = sel_s2_r;                 // [R14]
    end
    if (i_wr) begin
      unique case (i_addr)
        OFS_DIV_LOW:   div_low_nxt  = i_wdata;           // [R7]
        OFS_DIV_HIGH:  div_high_nxt = i_wdata;           // [R7]
        OFS_DIV_FRAC:  div_frac_nxt = i_wdata;           // [R8] [R9]
        OFS_MODEM_CTL: mcr_nxt      = i_wdata;           // [R3] [R14]
        default: begin
        end
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        OFS_DIV_LOW:   rdata_nxt = div_low_r;
        OFS_DIV_HIGH:  rdata_nxt = div_high_r;
        OFS_DIV_FRAC:  rdata_nxt = div_frac_r;
        OFS_MODEM_CTL: rdata_nxt = mcr_r;
        OFS_STATUS:    rdata_nxt = status;
        default:       rdata_nxt = 8'h00;
      endcase
      if (i_addr == OFS_STATUS) begin
        ref_seen_nxt = 1'b0;
      end
    end
    // A reference edge in the clearing read still sets the flag
    if (ref_rise) begin
      ref_seen_nxt = 1'b1;
    end
  end

  // Bus logic runs on i_mclk only, so a stopped reference never blocks it
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_low_r    <= RST_DIV_LOW;                       // [R6]
      div_high_r   <= RST_DIV_HIGH;                      // [R6]
      div_frac_r   <= RST_DIV_FRAC;                      // [R6]
      mcr_r        <= RST_MODEM_CTL;
      strap_done_r <= 1'b0;
      ref_seen_r   <= 1'b0;
      rdata_r      <= 8'h00;
    end else begin                                       // [R2]
      div_low_r    <= div_low_nxt;
      div_high_r   <= div_high_nxt;
      div_frac_r   <= div_frac_nxt;
      mcr_r        <= mcr_nxt;
      strap_done_r <= strap_done_nxt;
      ref_seen_r   <= ref_seen_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // Oscillator feedback pin mirrors the inverted reference
  logic osc_out_r;
  logic osc_out_nxt;
  always_comb begin
    osc_out_nxt = ~osc_s2_r;
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_out_r <= 1'b0;
    end else begin
      osc_out_r <= osc_out_nxt;
    end
  end
  assign o_oscillator_output = osc_out_r;

  // This channel's private prescaler and divider
  logic presc_tick;

  fbg_prescale u_presc (                                 // [R1]
    .i_mclk (i_mclk),
    .i_rst_b(i_rst_b),
    .i_tick (ref_rise),
    .i_div4 (mcr_r[MCR_PRESC_BIT]),                      // [R3]
    .o_tick (presc_tick)
  );

  assign dif.int_div  = {div_high_r, div_low_r};         // [R7]
  assign dif.frac     = div_frac_r[FRAC_LSB+:FRAC_W];    // [R8]
  assign dif.mode     = div_frac_r[MODE_LSB+:MODE_W];    // [R9]
  assign dif.ref_tick = presc_tick;

  fbg_frac_div u_div (                                   // [R1]
    .i_mclk (i_mclk),
    .i_rst_b(i_rst_b),
    .dif    (dif.div)
  );

  // Bit timer counting sampling ticks
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic       bit_r;
  logic       bit_nxt;
  logic       smp_r;
  logic       smp_nxt;
  logic [3:0] last;

  always_comb begin
    unique case (dif.act_mode)
      MODE_X8: last = LAST_X8;                           // [R9] [R15]
      MODE_X4: last = LAST_X4;                           // [R9] [R15]
      default: last = LAST_X16;                          // [R9] [R15]
    endcase
    bit_cnt_nxt = bit_cnt_r;
    bit_nxt     = 1'b0;
    smp_nxt     = dif.sample_tick;                       // [R5]
    if (dif.sample_tick) begin
      if (bit_cnt_r >= last) begin
        bit_cnt_nxt = 4'h0;
        bit_nxt     = 1'b1;                              // [R15]
      end else begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_cnt_r <= 4'h0;
      bit_r     <= 1'b0;
      smp_r     <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      bit_r     <= bit_nxt;
      smp_r     <= smp_nxt;
    end
  end

  assign o_sample_tick = smp_r;                          // [R5]
  assign o_bit_tick    = bit_r;                          // [R15]
endmodule

// ===== rtl/fbg_pkg.sv
// Shared constants and types of the fractional baud generator
package fbg_pkg;
  localparam int unsigned ADDR_W        = 3;
  localparam logic [2:0]  OFS_DIV_LOW   = 3'h0;
  localparam logic [2:0]  OFS_DIV_HIGH  = 3'h1;
  localparam logic [2:0]  OFS_DIV_FRAC  = 3'h2;
  localparam logic [2:0]  OFS_MODEM_CTL = 3'h3;
  localparam logic [2:0]  OFS_STATUS    = 3'h4;
  localparam logic [7:0]  RST_DIV_LOW   = 8'h01;
  localparam logic [7:0]  RST_DIV_HIGH  = 8'h00;
  localparam logic [7:0]  RST_DIV_FRAC  = 8'h00;
  localparam logic [7:0]  RST_MODEM_CTL = 8'h00;
  localparam int unsigned MCR_PRESC_BIT = 7;
  localparam int unsigned FRAC_LSB      = 0;
  localparam int unsigned FRAC_W        = 4;
  localparam int unsigned MODE_LSB      = 4;
  localparam int unsigned MODE_W        = 2;
  localparam int unsigned ST_PRESC_BIT  = 0;
  localparam int unsigned ST_REF_BIT    = 1;
  localparam int unsigned ST_MODE_LSB   = 4;
  localparam logic [1:0]  PRESC_LAST    = 2'h3;
  localparam logic [16:0] RST_PERIOD    = 17'h00001;
  localparam logic [16:0] ZERO_INT_LEN  = 17'h10000;
  localparam logic [1:0]  MODE_X16      = 2'h0;
  localparam logic [1:0]  MODE_X8       = 2'h1;
  localparam logic [1:0]  MODE_X4       = 2'h2;
  localparam logic [3:0]  LAST_X16      = 4'hF;
  localparam logic [3:0]  LAST_X8       = 4'h7;
  localparam logic [3:0]  LAST_X4       = 4'h3;
endpackage

// ===== rtl/fbg_div_if.sv
// Link between the register side and the fractional divider
`timescale 1ns/1ps
interface fbg_div_if;
  logic [15:0] int_div;
  logic [3:0]  frac;
  logic [1:0]  mode;
  logic        ref_tick;
  logic        sample_tick;
  logic [1:0]  act_mode;
  modport ctrl (output int_div, frac, mode, ref_tick,
                input  sample_tick, act_mode);
  modport div  (input  int_div, frac, mode, ref_tick,
                output sample_tick, act_mode);
endinterface

// ===== rtl/fbg_prescale.sv
// Divide-by-1 or divide-by-4 prescaler on reference ticks
`timescale 1ns/1ps
module fbg_prescale
  import fbg_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  input  wire logic i_tick,
  input  wire logic i_div4,
  output logic      o_tick
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (i_tick) begin
      cnt_nxt  = cnt_r + 2'h1;
      tick_nxt = i_div4 ? (cnt_r == PRESC_LAST) : 1'b1;  // [R3]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r  <= 2'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign o_tick = tick_r;
endmodule

// ===== rtl/fbg_frac_div.sv
// Integer plus sixteenths divider producing the sampling tick
`timescale 1ns/1ps
module fbg_frac_div
  import fbg_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  fbg_div_if.div    dif
);
  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic [16:0] len_r;
  logic [16:0] len_nxt;
  logic [3:0]  acc_r;
  logic [3:0]  acc_nxt;
  logic [1:0]  mode_r;
  logic [1:0]  mode_nxt;
  logic        smp_r;
  logic        smp_nxt;
  logic [4:0]  sum;
  logic [16:0] base;

  always_comb begin
    cnt_nxt  = cnt_r;
    len_nxt  = len_r;
    acc_nxt  = acc_r;
    mode_nxt = mode_r;
    smp_nxt  = 1'b0;
    sum      = {1'b0, acc_r} + {1'b0, dif.frac};
    base     = (dif.int_div == 16'h0000) ? ZERO_INT_LEN
                                         : {1'b0, dif.int_div};
    if (dif.ref_tick) begin
      if (cnt_r >= len_r - 17'h00001) begin
        // Reload only at a period end so no pulse is ever cut short
        smp_nxt  = 1'b1;                         // [R4] [R17]
        cnt_nxt  = 17'h00000;
        acc_nxt  = sum[3:0];                     // [R16]
        len_nxt  = base + {16'h0000, sum[4]};    // [R16] [R10]
        mode_nxt = dif.mode;                     // [R17]
      end else begin
        cnt_nxt = cnt_r + 17'h00001;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r  <= 17'h00000;
      len_r  <= RST_PERIOD;
      acc_r  <= 4'h0;
      mode_r <= MODE_X16;
      smp_r  <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      len_r  <= len_nxt;
      acc_r  <= acc_nxt;
      mode_r <= mode_nxt;
      smp_r  <= smp_nxt;
    end
  end

  assign dif.sample_tick = smp_r;
  assign dif.act_mode    = mode_r;
endmodule

// ===== sim/fbg_baud_gen_chk.sv
// Port assertions for the fractional baud generator
`timescale 1ns/1ps
module fbg_chk
  import fbg_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_b,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [7:0]        o_rdata,
  input  wire logic              i_oscillator_input,
  input  wire logic              o_oscillator_output,
  input  wire logic              i_prescaler_default_select_pin,
  input  wire logic              o_sample_tick,
  input  wire logic              o_bit_tick
);
  logic [2:0] age_r, age_nxt;
  logic [4:0] smp_r, smp_nxt;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // Age gate keeps $past away from values of the reset period
  always_comb begin
    age_nxt = (age_r == 3'h7) ? age_r : age_r + 3'h1;
    smp_nxt = o_bit_tick ? 5'h00 : smp_r + {4'h0, o_sample_tick};
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      age_r <= 3'h0;
      smp_r <= 5'h00;
    end else begin
      age_r <= age_nxt;
      smp_r <= smp_nxt;
    end
  end
  sequence s_wr;
    i_wr && i_addr < 3'h3;
  endsequence
  sequence s_smp_gap;
    !o_sample_tick [*3];
  endsequence
  // Write, one idle cycle, then a read of the same register
  sequence s_wr_rd;
    s_wr ##2 (i_rd && i_addr == $past(i_addr, 2));
  endsequence
  property p_readback;
    s_wr_rd |=> o_rdata == $past(i_wdata, 3);
  endproperty
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_rd_a: assert property (i_rd && i_addr > 3'h4 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  readback_a: assert property (p_readback)
    else $error("divisor register readback wrong");
  smp_space_a: assert property (o_sample_tick |=> s_smp_gap)
    else $error("sampling ticks too close");
  bit_smp_a: assert property (o_bit_tick |-> o_sample_tick)
    else $error("bit tick without sampling tick");
  bit_space_a: assert property (o_bit_tick |=> !o_bit_tick [*8])
    else $error("bit ticks too close");
  bit_count_a: assert property (smp_r < 5'h10)
    else $error("more than sixteen samples in a bit");
  osc_out_a: assert property (age_r == 3'h7 |->
      o_oscillator_output == !$past(i_oscillator_input, 3))
    else $error("oscillator output not inverse of input");
endmodule

// ===== sim/fbg_shift_model.sv
// Channel shift logic model: counts sampling ticks in each bit time
`timescale 1ns/1ps
module fbg_shift_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_sample_tick,
  input  wire logic       i_bit_tick,
  output logic      [4:0] o_bit_len
);
  logic [4:0] cnt_r, cnt_nxt, len_r, len_nxt;
  always_comb begin
    cnt_nxt = i_bit_tick ? 5'h00 : cnt_r + {4'h0, i_sample_tick};
    len_nxt = i_bit_tick ? cnt_r + 5'h01 : len_r;
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= 5'h00;
      len_r <= 5'h00;
    end else begin
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
    end
  end
  assign o_bit_len = len_r;
endmodule

// ===== sim/tb_fractional_baud_rate_generator.sv
// Self-checking bench of the fractional baud generator
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_fractional_baud_rate_generator;
  import fbg_pkg::*;
  logic              i_mclk, i_rst_b, i_wr, i_rd, i_oscillator_input;
  logic              i_prescaler_default_select_pin, ref_en;
  logic [ADDR_W-1:0] i_addr;
  logic [7:0]        i_wdata, o_rdata;
  logic              o_oscillator_output, o_sample_tick, o_bit_tick;
  logic [4:0]        bit_len;
  logic [1:0]        ref_cnt;
  int                num_errors = 0;
  int                tests_run = 0;
  fbg_baud_gen uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_oscillator_input(i_oscillator_input),
    .o_oscillator_output(o_oscillator_output),
    .i_prescaler_default_select_pin(i_prescaler_default_select_pin),
    .o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick));
  fbg_shift_model u_far (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_sample_tick(o_sample_tick), .i_bit_tick(o_bit_tick),
    .o_bit_len(bit_len));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Reference of six clock periods, stopped while ref_en is low
  always @(posedge i_mclk) begin
    if (ref_en) begin
      ref_cnt <= (ref_cnt == 2'h2) ? 2'h0 : ref_cnt + 2'h1;
      if (ref_cnt == 2'h2) i_oscillator_input <= !i_oscillator_input;
    end
  end
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    `CHK(o_rdata, e)
    @(posedge i_mclk);
  endtask
  task automatic wait_bit;
    int k;
    k = 0;
    do begin
      @(negedge i_mclk);
      k++;
    end while (o_bit_tick !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      num_errors++;
      finish_test();
    end
  endtask
  // Sixteen sampling periods from a bit boundary, so fraction carries add up
  task automatic measure(input int cyc_e, input int bits_e,
                         input logic [4:0] len_e);
    int cyc, n, nb;
    cyc = 0;
    n = 0;
    nb = 0;
    repeat (2) wait_bit();
    while (n < 16 && cyc < 20000) begin
      @(negedge i_mclk);
      cyc++;
      n += int'(o_sample_tick);
      nb += int'(o_bit_tick);
    end
    `CHK(cyc, cyc_e)
    `CHK(nb, bits_e)
    `CHK(bit_len, len_e)
    @(posedge i_mclk);
  endtask
  task automatic t_reset;
    rd_chk(3'h0, 8'h01);
    rd_chk(3'h1, 8'h00);
    rd_chk(3'h2, 8'h00);
    rd_chk(3'h3, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    wr(3'h0, 8'hA6);
    rd_chk(3'h0, 8'hA6);
    wr(3'h1, 8'h0E);
    rd_chk(3'h1, 8'h0E);
    wr(3'h2, 8'h3F);
    rd_chk(3'h2, 8'h3F);
    wr(3'h5, 8'h5A);
    rd_chk(3'h5, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_rate;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h02);
    wr(3'h2, 8'h03);
    measure(6 * (16 * 2 + 3), 1, 5'h10);
    for (int m = 0; m < 3; m++) begin
      wr(3'h2, {2'h0, 2'(m), 4'h0});
      measure(6 * 32, 1 << m, 5'(16 >> m));
    end
    $display("t_rate done");
  endtask
  task automatic t_strap;
    i_prescaler_default_select_pin <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rd_chk(3'h3, 8'h80);
    measure(6 * 4 * 16, 1, 5'h10);
    wr(3'h3, 8'h00);
    rd_chk(3'h4, 8'h02);
    measure(6 * 16, 1, 5'h10);
    $display("t_strap done");
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = 8'h00;
    i_oscillator_input = 1'b0;
    i_prescaler_default_select_pin = 1'b0;
    ref_en = 1'b0;
    ref_cnt = 2'h0;
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(posedge i_mclk);
    t_reset();
    t_regs();
    ref_en <= 1'b1;
    t_rate();
    t_strap();
    finish_test();
  end
endmodule
bind fbg_baud_gen fbg_chk u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_oscillator_input(i_oscillator_input),
  .o_oscillator_output(o_oscillator_output),
  .i_prescaler_default_select_pin(i_prescaler_default_select_pin),
  .o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick));
